// *** fgtr_pkg.sv ***
// Purpose: Shared constants for the fine gain trim register bank
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Offsets below are word indices; byte address is index * 4
package fgtr_pkg;

  // Register word indices; byte address is the index shifted left twice
  localparam int unsigned     FGTR_IDX_W       = 10;
  localparam logic [9:0]      FGTR_IDX_CONV2_B = 10'h363;
  localparam logic [9:0]      FGTR_IDX_CONV3_C = 10'h364;
  localparam logic [9:0]      FGTR_IDX_CONV3_D = 10'h365;
  localparam logic [9:0]      FGTR_IDX_CONV4   = 10'h366;
  localparam logic [9:0]      FGTR_IDX_CONV5   = 10'h367;
  localparam int unsigned     FGTR_BYTE_SHIFT  = 2;
  localparam logic [1:0]      FGTR_WORD_ALIGN  = 2'h0;

  // Smallest byte address width that reaches the top register
  localparam int unsigned     FGTR_ADDR_W      = 12;

  // Field layout: gain in bits 4:0, bits 7:5 reserved
  localparam int unsigned     FGTR_REG_W       = 8;
  localparam int unsigned     FGTR_GAIN_W      = 5;
  localparam int unsigned     FGTR_DATA_W      = 32;
  localparam logic [4:0]      FGTR_GAIN_RESET  = 5'h00;

  // Storage slots, in address order
  localparam int unsigned     FGTR_NUM_REGS    = 5;
  localparam int unsigned     FGTR_SLOT_W      = 3;
  localparam logic [2:0]      FGTR_SLOT_C2B    = 3'h0;
  localparam logic [2:0]      FGTR_SLOT_C3C    = 3'h1;
  localparam logic [2:0]      FGTR_SLOT_C3D    = 3'h2;
  localparam logic [2:0]      FGTR_SLOT_C4     = 3'h3;
  localparam logic [2:0]      FGTR_SLOT_C5     = 3'h4;

endpackage

// *** fgtr_pin_sync.sv ***
// Purpose: Three-stage synchroniser for pin-level inputs
// Assumes: Inputs are slow levels from outside the pclk domain
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/100ps
module fgtr_pin_sync
  import fgtr_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else if (clk_en)
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per bit: follow when stages agree, otherwise hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_out <= '0;
    else if (clk_en)
      sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
  end

endmodule

// *** fgtr_trim_route.sv ***
// Purpose: Routes stored gain trims to the converter channels
// Assumes: Select levels are already synchronised to pclk
// Notes:   All trim outputs are registered
`timescale 1ns/100ps
module fgtr_trim_route
  import fgtr_pkg::*;
#(
  parameter int unsigned GAIN_W = FGTR_GAIN_W
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              conv2_sel_b,
  input  wire logic              conv3_sel_d,
  input  wire logic [GAIN_W-1:0] gain_c2b,
  input  wire logic [GAIN_W-1:0] gain_c3c,
  input  wire logic [GAIN_W-1:0] gain_c3d,
  input  wire logic [GAIN_W-1:0] gain_c4,
  input  wire logic [GAIN_W-1:0] gain_c5,
  output logic      [GAIN_W-1:0] conv2_trim,
  output logic                   conv2_trim_active,
  output logic      [GAIN_W-1:0] conv3_trim,
  output logic      [GAIN_W-1:0] conv4_trim,
  output logic      [GAIN_W-1:0] conv5_trim
);

  ////////////////////////////////////////////////////////////////////////////
  // Converter 2 trim only while on its second input; zero otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv2_trim        <= '0;
      conv2_trim_active <= 1'b0;
    end
    else if (clk_en)
    begin
      conv2_trim        <= conv2_sel_b ? gain_c2b : '0; // R2
      conv2_trim_active <= conv2_sel_b; // R2
    end
  end

  // Converter 3 follows whichever input pair it samples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv3_trim <= '0;
    else if (clk_en)
      conv3_trim <= conv3_sel_d ? gain_c3d : gain_c3c; // R3 R4
  end

  // Converters 4 and 5 ignore input selection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv4_trim <= '0;
      conv5_trim <= '0;
    end
    else if (clk_en)
    begin
      conv4_trim <= gain_c4; // R5
      conv5_trim <= gain_c5; // R6
    end
  end

endmodule

// *** fgtr_regs.sv ***
// Purpose: Fine gain trim register bank behind an APB slave
// Assumes: APB3 signalling, pclk at 100 MHz, fuse data stable when valid
// Notes:   Fuse defaults load once after reset unless software got there
`timescale 1ns/100ps
// Functional notes
// R1: Five byte registers, gain 4:0, reserved 7:5
// R2: Slot 0 trims converter 2 on input B
// R3: Slot 1 trims converter 3 on input C
// R4: Slot 2 trims converter 3 on input D
// R5: Slot 3 always trims converter 4
// R6: Slot 4 always trims converter 5
// R7: Software writes reserved bits as zero
// R8: Gain defaults come from fuse storage
// R9: Reads return last write, fuse default, or zero before the fuse load
module fgtr_regs
  import fgtr_pkg::*;
#(
  parameter int unsigned ADDR_W = FGTR_ADDR_W,
  parameter int unsigned GAIN_W = FGTR_GAIN_W
)
(
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire logic                                  clk_en,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [ADDR_W-1:0]                     paddr,
  input  wire logic [FGTR_DATA_W-1:0]                pwdata,
  output logic      [FGTR_DATA_W-1:0]                prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic [FGTR_NUM_REGS-1:0][GAIN_W-1:0]  fuse_gain,
  input  wire logic                                  fuse_valid,
  input  wire logic                                  conv2_sel_b,
  input  wire logic                                  conv3_sel_d,
  output logic      [GAIN_W-1:0]                     conv2_trim,
  output logic                                       conv2_trim_active,
  output logic      [GAIN_W-1:0]                     conv3_trim,
  output logic      [GAIN_W-1:0]                     conv4_trim,
  output logic      [GAIN_W-1:0]                     conv5_trim
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  generate
    if (ADDR_W < FGTR_ADDR_W || GAIN_W < 1 || GAIN_W > FGTR_REG_W)
    begin : g_bad_params
      $error("fgtr_regs: unsupported ADDR_W or GAIN_W");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [FGTR_NUM_REGS-1:0][GAIN_W-1:0] gain;
  logic [FGTR_NUM_REGS-1:0]             written;
  logic                                 ld_done;
  logic                                 ld_now;
  logic                                 xfer_ok;
  logic                                 hit_q;
  logic [FGTR_SLOT_W-1:0]               idx_q;
  logic                                 done;
  logic                                 wr_now;
  logic                                 dec_hit;
  logic [FGTR_SLOT_W-1:0]               dec_idx;
  logic                                 fuse_valid_s;
  logic                                 conv2_sel_b_s;
  logic                                 conv3_sel_d_s;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Hit needs word alignment and an index inside the bank
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [FGTR_IDX_W-1:0] word;
    word = a[FGTR_BYTE_SHIFT +: FGTR_IDX_W];
    return (a[FGTR_BYTE_SHIFT-1:0] == FGTR_WORD_ALIGN) &&
           (a[ADDR_W-1:FGTR_BYTE_SHIFT] ==
            (ADDR_W-FGTR_BYTE_SHIFT)'(word)) &&
           (word >= FGTR_IDX_CONV2_B) && (word <= FGTR_IDX_CONV5);
  endfunction

  function automatic logic [FGTR_SLOT_W-1:0] addr_slot(
    input logic [ADDR_W-1:0] a);
    logic [FGTR_IDX_W-1:0] word;
    word = a[FGTR_BYTE_SHIFT +: FGTR_IDX_W];
    return FGTR_SLOT_W'(word - FGTR_IDX_CONV2_B);
  endfunction

  assign dec_hit = addr_hit(paddr); // R1
  assign dec_idx = addr_slot(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake

  // Frozen clock enable stalls the bus instead of dropping a transfer
  assign pready  = psel & penable & xfer_ok & clk_en;
  assign pslverr = pready & ~hit_q;
  assign done    = psel & penable & pready;
  assign wr_now  = done & pwrite & hit_q;

  // Capture decode and read data while a transfer is open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xfer_ok <= 1'b0;
      hit_q   <= 1'b0;
      idx_q   <= FGTR_SLOT_C2B;
      prdata  <= '0;
    end
    else if (clk_en)
    begin
      if (done)
        xfer_ok <= 1'b0;
      else if (psel)
      begin
        xfer_ok <= 1'b1;
        hit_q   <= dec_hit;
        idx_q   <= dec_idx;
        // Reserved bits and unmapped words read as zero
        prdata  <= dec_hit ? FGTR_DATA_W'(gain[dec_idx]) : '0; // R1 R9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  fgtr_pin_sync #(
    .W        (3)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .pin_in   ({fuse_valid, conv3_sel_d, conv2_sel_b}),
    .sync_out ({fuse_valid_s, conv3_sel_d_s, conv2_sel_b_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gain storage

  // Fuse load waits for an idle bus so a read never sees it mid-transfer
  assign ld_now = fuse_valid_s & ~ld_done & ~psel;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ld_done <= 1'b0;
    else if (clk_en && ld_now)
      ld_done <= 1'b1; // R8
  end

  // Software write beats the fuse default, even in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      written <= '0;
    else if (clk_en)
    begin
      for (int i = 0; i < FGTR_NUM_REGS; i++)
      begin
        if (wr_now && idx_q == FGTR_SLOT_W'(i))
          written[i] <= 1'b1; // R9
      end
    end
  end

  // Reserved write bits are dropped, not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain <= {FGTR_NUM_REGS{GAIN_W'(FGTR_GAIN_RESET)}}; // R8
    else if (clk_en)
    begin
      for (int i = 0; i < FGTR_NUM_REGS; i++)
      begin
        if (wr_now && idx_q == FGTR_SLOT_W'(i))
          gain[i] <= pwdata[GAIN_W-1:0]; // R1 R9
        else if (ld_now && !written[i])
          gain[i] <= fuse_gain[i]; // R8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trim routing

  fgtr_trim_route #(
    .GAIN_W            (GAIN_W)
  ) u_trim_route (
    .pclk              (pclk),
    .presetn           (presetn),
    .clk_en            (clk_en),
    .conv2_sel_b       (conv2_sel_b_s),
    .conv3_sel_d       (conv3_sel_d_s),
    .gain_c2b          (gain[FGTR_SLOT_C2B]),
    .gain_c3c          (gain[FGTR_SLOT_C3C]),
    .gain_c3d          (gain[FGTR_SLOT_C3D]),
    .gain_c4           (gain[FGTR_SLOT_C4]),
    .gain_c5           (gain[FGTR_SLOT_C5]),
    .conv2_trim        (conv2_trim),
    .conv2_trim_active (conv2_trim_active),
    .conv3_trim        (conv3_trim),
    .conv4_trim        (conv4_trim),
    .conv5_trim        (conv5_trim)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_reserved_read_zero: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite |-> prdata[FGTR_DATA_W-1:GAIN_W] == '0)
    else $error("reserved read bits not zero");

  a_unmapped_no_write: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    clk_en && done && !hit_q && pwrite |=> $stable(gain))
    else $error("unmapped write changed a gain");

  a_conv2_gated: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) |->
      conv2_trim_active == $past(conv2_sel_b_s) &&
      conv2_trim == ($past(conv2_sel_b_s) ?
                     $past(gain[FGTR_SLOT_C2B]) : '0))
    else $error("converter 2 trim not gated by input select");

  a_conv3_input_c: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) && !$past(conv3_sel_d_s) |->
      conv3_trim == $past(gain[FGTR_SLOT_C3C]))
    else $error("converter 3 trim wrong on input C");

  a_conv3_input_d: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) && $past(conv3_sel_d_s) |->
      conv3_trim == $past(gain[FGTR_SLOT_C3D]))
    else $error("converter 3 trim wrong on input D");

  a_conv4_follow: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) |-> conv4_trim == $past(gain[FGTR_SLOT_C4]))
    else $error("converter 4 trim does not follow register");

  a_conv5_follow: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    $past(clk_en) |-> conv5_trim == $past(gain[FGTR_SLOT_C5]))
    else $error("converter 5 trim does not follow register");

  a_fuse_default_load: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    clk_en && ld_now && !written[FGTR_SLOT_C5] |=>
      gain[FGTR_SLOT_C5] == $past(fuse_gain[FGTR_SLOT_C5]) && ld_done)
    else $error("fuse default not loaded");

  a_write_stores: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr_now |=>
      gain[$past(idx_q)] == $past(pwdata[GAIN_W-1:0]) &&
      written[$past(idx_q)])
    else $error("write did not store gain");

  a_read_returns: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && hit_q |->
      prdata[GAIN_W-1:0] == gain[idx_q])
    else $error("read data differs from stored gain");

  c_mapped_write: cover property (
    @(posedge pclk) disable iff (!presetn)
    wr_now);

  c_mapped_read: cover property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && hit_q);

  c_error_reply: cover property (
    @(posedge pclk) disable iff (!presetn)
    pslverr);

  c_fuse_load: cover property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && ld_now);

  c_conv3_switch: cover property (
    @(posedge pclk) disable iff (!presetn)
    $rose(conv3_sel_d_s));

endmodule

// *** fgtr_regs_tb.sv ***
// Purpose: Self-checking bench for the fine gain trim register bank
// Assumes: APB slave answers once clk_en is high, pins settle in 4 edges
// Notes:   Pin changes get 8 cycles; fuse load gets 10 cycles
`timescale 1ns/100ps
module fgtr_regs_tb
  import fgtr_pkg::*;
;

  logic                                 pclk;
  logic                                 presetn;
  logic                                 clk_en;
  logic                                 psel;
  logic                                 penable;
  logic                                 pwrite;
  logic [11:0]                          paddr;
  logic [31:0]                          pwdata;
  logic [31:0]                          prdata;
  logic                                 pready;
  logic                                 pslverr;
  logic [FGTR_NUM_REGS-1:0][4:0]        fuse_gain;
  logic                                 fuse_valid;
  logic                                 conv2_sel_b;
  logic                                 conv3_sel_d;
  logic [4:0]                           conv2_trim;
  logic                                 conv2_trim_active;
  logic [4:0]                           conv3_trim;
  logic [4:0]                           conv4_trim;
  logic [4:0]                           conv5_trim;
  int                                   bad_count;
  int                                   n_tests;
  logic [4:0]                           exp_g [5];
  logic [9:0]                           idx   [5];

  fgtr_regs i_fgtr_regs (
    .pclk              (pclk),
    .presetn           (presetn),
    .clk_en            (clk_en),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .fuse_gain         (fuse_gain),
    .fuse_valid        (fuse_valid),
    .conv2_sel_b       (conv2_sel_b),
    .conv3_sel_d       (conv3_sel_d),
    .conv2_trim        (conv2_trim),
    .conv2_trim_active (conv2_trim_active),
    .conv3_trim        (conv3_trim),
    .conv4_trim        (conv4_trim),
    .conv5_trim        (conv5_trim)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, FGTR_WORD_ALIGN};
  endfunction

  // Ready and the answer are taken at the rising edge that ends the access
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int w = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        rd  = prdata;
        err = pslverr;
        break;
      end
      w++;
      if (w > 200)
      begin
        bad_count++;
        end_of_test();
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d,
                        input logic e_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk({31'h0, err}, {31'h0, e_err});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [4:0] g,
                        input logic e_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, {27'h0, g});
    chk({31'h0, err}, {31'h0, e_err});
  endtask

  task automatic rd_all;
    for (int i = 0; i < 5; i++)
      rd_chk(ba(idx[i]), exp_g[i], 1'b0);
  endtask

  task automatic trims(input logic sb, input logic sd);
    @(negedge pclk);
    chk({27'h0, conv2_trim}, {27'h0, sb ? exp_g[0] : 5'h00});
    chk({31'h0, conv2_trim_active}, {31'h0, sb});
    chk({27'h0, conv3_trim}, {27'h0, sd ? exp_g[2] : exp_g[1]});
    chk({27'h0, conv4_trim}, {27'h0, exp_g[3]});
    chk({27'h0, conv5_trim}, {27'h0, exp_g[4]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fuse;
    for (int i = 0; i < 5; i++)
      rd_chk(ba(idx[i]), 5'h00, 1'b0);
    wr_reg(ba(idx[3]), 32'h0000000a, 1'b0);
    @(posedge pclk);
    fuse_valid <= 1'b1;
    repeat (10) @(posedge pclk);
    exp_g[3] = 5'h0a;
    rd_all();
  endtask

  // Second reset drops the early write; fuse defaults return
  task automatic t_reset2;
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk({27'h0, conv4_trim}, 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    exp_g[3] = 5'h1c;
    rd_all();
  endtask

  task automatic t_rw_all;
    logic [4:0] v [5];
    v = '{5'h1f, 5'h0a, 5'h15, 5'h01, 5'h10};
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(ba(idx[i]), {27'h0, v[i]}, 1'b0);
      exp_g[i] = v[i];
    end
    rd_all();
  endtask

  task automatic t_unmapped;
    logic [11:0] bad [4];
    bad = '{ba(10'h362), ba(10'h368), ba(idx[0]) | 12'h001, 12'h000};
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(bad[i], 32'h0000001f, 1'b1);
      rd_chk(bad[i], 5'h00, 1'b1);
    end
    rd_all();
  endtask

  task automatic t_route;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      conv2_sel_b <= k[0];
      conv3_sel_d <= k[1];
      repeat (8) @(posedge pclk);
      trims(k[0], k[1]);
    end
    wr_reg(ba(idx[3]), 32'h00000007, 1'b0);
    exp_g[3] = 5'h07;
    repeat (2) @(posedge pclk);
    trims(1'b1, 1'b1);
  endtask

  // Stalled clock enable must hold the answer back
  task automatic t_clk_en;
    @(posedge pclk);
    clk_en <= 1'b0;
    fork
      wr_reg(ba(idx[4]), 32'h0000000c, 1'b0);
      begin
        repeat (6)
        begin
          @(negedge pclk);
          chk({31'h0, pready}, 32'h0);
        end
        @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    exp_g[4] = 5'h0c;
    rd_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever
      #5 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    bad_count   = 0;
    n_tests     = 0;
    presetn     = 1'b0;
    clk_en      = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    fuse_valid  = 1'b0;
    conv2_sel_b = 1'b0;
    conv3_sel_d = 1'b0;
    idx = '{FGTR_IDX_CONV2_B, FGTR_IDX_CONV3_C, FGTR_IDX_CONV3_D,
            FGTR_IDX_CONV4, FGTR_IDX_CONV5};
    for (int i = 0; i < 5; i++)
    begin
      fuse_gain[i] = 5'h19 + i[4:0];
      exp_g[i]     = 5'h19 + i[4:0];
    end
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_fuse();
    t_reset2();
    t_rw_all();
    t_unmapped();
    t_route();
    t_clk_en();
    end_of_test();
  end

endmodule
